/* File: pkg/fpp_pkg.sv */
// constants, register map and carrier types of the four-pin port
package fpp_pkg;

   // register bus geometry
   localparam int FPP_DATA_W = 8;
   localparam int FPP_ADDR_W = 3;

   // register offsets
   localparam logic [2:0] FPP_OFS_PORT_DATA = 3'h0;
   localparam logic [2:0] FPP_OFS_OUT_LATCH = 3'h1;
   localparam logic [2:0] FPP_OFS_DIRECTION = 3'h2;
   localparam logic [2:0] FPP_OFS_ANALOG_SEL = 3'h3;
   localparam logic [2:0] FPP_OFS_INTR_CTL_TWO = 3'h4;
   localparam logic [2:0] FPP_OFS_CFG_THREE_HIGH = 3'h5;
   localparam logic [2:0] FPP_OFS_CFG_FOUR_LOW = 3'h6;

   // pin counts and field positions
   localparam int FPP_GEN_PINS = 3;
   localparam int FPP_ALL_PINS = 4;
   localparam int FPP_INPUT_PIN_BIT = 3;
   localparam int FPP_PULLUP_EN_BIT = 7;
   localparam int FPP_GLOBAL_PU_DIS_BIT = 7;
   localparam int FPP_MASTER_CLEAR_INPUT_SEL_BIT = 7;
   localparam int FPP_LVP_BIT = 2;
   localparam int FPP_COMPANION_PINS = 8;
   localparam int FPP_SYNC_STAGES = 3;

   // writable bits of each register
   localparam logic [7:0] FPP_MASK_GEN = 8'h07;
   localparam logic [7:0] FPP_MASK_DIRECTION = 8'h87;
   localparam logic [7:0] FPP_MASK_INTR_CTL_TWO = 8'h80;
   localparam logic [7:0] FPP_MASK_CFG_THREE_HIGH = 8'h80;
   localparam logic [7:0] FPP_MASK_CFG_FOUR_LOW = 8'h04;

   // reset values
   localparam logic [7:0] FPP_RST_DIRECTION = 8'h07;
   localparam logic [7:0] FPP_RST_OUT_LATCH = 8'h00;
   localparam logic [7:0] FPP_RST_ANALOG_SEL = 8'h07;
   localparam logic [7:0] FPP_RST_INTR_CTL_TWO = 8'h80;
   localparam logic [7:0] FPP_RST_CFG_THREE_HIGH = 8'h80;
   localparam logic [7:0] FPP_RST_CFG_FOUR_LOW = 8'h04;
   localparam logic [3:0] FPP_RST_SYNC = 4'hf;
   localparam logic [7:0] FPP_READ_ZERO = 8'h00;

   // register bus request
   typedef struct packed {
      logic [FPP_ADDR_W-1:0] addr;
      logic [FPP_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } fpp_bus_req_type;

   // drive of the three general pins
   typedef struct packed {
      logic [FPP_GEN_PINS-1:0] level;
      logic [FPP_GEN_PINS-1:0] oe_n;
   } fpp_pin_drive_type;

   // weak pull-up enables toward the pads
   typedef struct packed {
      logic input_pin;
      logic [FPP_COMPANION_PINS-1:0] companion;
   } fpp_pullup_type;

endpackage

/* File: hw/fpp_pin_sync.sv */
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module fpp_pin_sync
   import fpp_pkg::*;
#(
   parameter int WIDTH = FPP_ALL_PINS,
   parameter logic [WIDTH-1:0] RST_VALUE = '1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // asynchronous levels in
   input wire logic [WIDTH-1:0] async_in,
   // settled levels out
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] stage_three;

   always_ff @(posedge clk) begin
      if (srst) begin
         stage_one <= RST_VALUE;
         stage_two <= RST_VALUE;
         stage_three <= RST_VALUE;
      end else begin
         stage_one <= async_in;
         stage_two <= stage_one;
         stage_three <= stage_two;
      end
   end

   // per bit: take the new level only when the last two stages match
   always_ff @(posedge clk) begin
      if (srst) begin
         sync_out <= RST_VALUE;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage_two[i] == stage_three[i]) begin
               sync_out[i] <= stage_three[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: hw/fpp_port.sv */
// four-pin port: three bidirectional pins, one input-only pin shared with master clear
`timescale 1ns/1ns
`default_nettype none

module fpp_port
   import fpp_pkg::*;
#(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register bus
   input wire fpp_bus_req_type bus_req,
   output logic [FPP_DATA_W-1:0] bus_rdata,
   // pad levels, bit 3 is the input-only pin
   input wire logic [FPP_ALL_PINS-1:0] pin_in,
   // general pin drive, enable low while driving
   output fpp_pin_drive_type pin_drive,
   // companion port pull-up requests
   input wire logic [FPP_COMPANION_PINS-1:0] companion_port_pullup_bits,
   // weak pull-up enables to the pads
   output fpp_pullup_type weak_pullup,
   // analog mode of the general pins
   output logic [FPP_GEN_PINS-1:0] analog_select_out,
   // master clear reset request, high while the pin asks for reset
   output logic master_clear_input
);

   // registers
   logic [FPP_DATA_W-1:0] output_latch;
   logic [FPP_DATA_W-1:0] pin_direction_bits;
   logic [FPP_DATA_W-1:0] analog_select_bits;
   logic [FPP_DATA_W-1:0] interrupt_control_two;
   logic [FPP_DATA_W-1:0] config_word_three_high;
   logic [FPP_DATA_W-1:0] config_word_four_low;

   // decoded controls
   logic [FPP_DATA_W-1:0] gen_mask;
   logic [FPP_DATA_W-1:0] wmask_direction;
   logic master_clear_select;
   logic low_voltage_program_enable;
   logic global_pullup_disable_n;
   logic input_pin_pullup_enable;
   logic input_pin_pullup_forced;
   logic input_pin_present;

   // pin levels
   logic [FPP_ALL_PINS-1:0] pin_level;
   logic [FPP_DATA_W-1:0] fourth_port_pins;
   logic [FPP_DATA_W-1:0] next_rdata;

   // write strobes per register
   logic wr_port_data;
   logic wr_out_latch;
   logic wr_direction;
   logic wr_analog_sel;
   logic wr_intr_ctl_two;
   logic wr_cfg_three_high;
   logic wr_cfg_four_low;

   // general pins exist only on the large package
   assign gen_mask = LARGE_PACKAGE ? FPP_MASK_GEN : FPP_READ_ZERO;
   // pull-up enable bit sits beside the direction bits
   assign wmask_direction = FPP_MASK_DIRECTION & (gen_mask | ~FPP_MASK_GEN);

   assign master_clear_select = config_word_three_high[FPP_MASTER_CLEAR_INPUT_SEL_BIT];
   assign low_voltage_program_enable = config_word_four_low[FPP_LVP_BIT];
   assign global_pullup_disable_n = interrupt_control_two[FPP_GLOBAL_PU_DIS_BIT];
   assign input_pin_pullup_enable = pin_direction_bits[FPP_PULLUP_EN_BIT];

   // both packages: pin serves the port only without master clear
   assign input_pin_present = ~master_clear_select;

   // address decode
   always_comb begin
      wr_port_data = 1'b0;
      wr_out_latch = 1'b0;
      wr_direction = 1'b0;
      wr_analog_sel = 1'b0;
      wr_intr_ctl_two = 1'b0;
      wr_cfg_three_high = 1'b0;
      wr_cfg_four_low = 1'b0;
      if (bus_req.wr) begin
         case (bus_req.addr)
            FPP_OFS_PORT_DATA: begin
               wr_port_data = 1'b1;
            end
            FPP_OFS_OUT_LATCH: begin
               wr_out_latch = 1'b1;
            end
            FPP_OFS_DIRECTION: begin
               wr_direction = 1'b1;
            end
            FPP_OFS_ANALOG_SEL: begin
               wr_analog_sel = 1'b1;
            end
            FPP_OFS_INTR_CTL_TWO: begin
               wr_intr_ctl_two = 1'b1;
            end
            FPP_OFS_CFG_THREE_HIGH: begin
               wr_cfg_three_high = 1'b1;
            end
            FPP_OFS_CFG_FOUR_LOW: begin
               wr_cfg_four_low = 1'b1;
            end
            default: begin
               wr_port_data = 1'b0;
            end
         endcase
      end
   end

   // output latch: written directly or through the port data address
   always_ff @(posedge clk) begin
      if (srst) begin
         output_latch <= FPP_RST_OUT_LATCH;
      end else if (wr_out_latch || wr_port_data) begin
         output_latch <= bus_req.wdata & gen_mask;
      end
   end

   // direction bits and the input pin pull-up enable
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_direction_bits <= FPP_RST_DIRECTION & wmask_direction;
      end else if (wr_direction) begin
         pin_direction_bits <= bus_req.wdata & wmask_direction;
      end
   end

   // analog selection, every general pin analog after reset
   always_ff @(posedge clk) begin
      if (srst) begin
         analog_select_bits <= FPP_RST_ANALOG_SEL & gen_mask;
      end else if (wr_analog_sel) begin
         analog_select_bits <= bus_req.wdata & gen_mask;
      end
   end

   // shared global pull-up disable, set after reset
   always_ff @(posedge clk) begin
      if (srst) begin
         interrupt_control_two <= FPP_RST_INTR_CTL_TWO;
      end else if (wr_intr_ctl_two) begin
         interrupt_control_two <= bus_req.wdata & FPP_MASK_INTR_CTL_TWO;
      end
   end

   // configuration words holding master clear select and low-voltage programming
   always_ff @(posedge clk) begin
      if (srst) begin
         config_word_three_high <= FPP_RST_CFG_THREE_HIGH;
      end else if (wr_cfg_three_high) begin
         config_word_three_high <= bus_req.wdata & FPP_MASK_CFG_THREE_HIGH;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         config_word_four_low <= FPP_RST_CFG_FOUR_LOW;
      end else if (wr_cfg_four_low) begin
         config_word_four_low <= bus_req.wdata & FPP_MASK_CFG_FOUR_LOW;
      end
   end

   // pad inputs into the clock domain
   fpp_pin_sync #(
      .WIDTH(FPP_ALL_PINS),
      .RST_VALUE(FPP_RST_SYNC)
   ) u_pin_sync (
      .clk(clk),
      .srst(srst),
      .async_in(pin_in),
      .sync_out(pin_level)
   );

   // port data view: analog pins and absent pins read zero
   always_comb begin
      fourth_port_pins = FPP_READ_ZERO;
      for (int i = 0; i < FPP_GEN_PINS; i++) begin
         fourth_port_pins[i] = pin_level[i] & gen_mask[i] & ~analog_select_bits[i];
      end
      fourth_port_pins[FPP_INPUT_PIN_BIT] =
         pin_level[FPP_INPUT_PIN_BIT] & input_pin_present;
   end

   // read data, one cycle after the strobe
   always_comb begin
      next_rdata = FPP_READ_ZERO;
      case (bus_req.addr)
         FPP_OFS_PORT_DATA: begin
            next_rdata = fourth_port_pins;
         end
         FPP_OFS_OUT_LATCH: begin
            next_rdata = output_latch;
         end
         FPP_OFS_DIRECTION: begin
            next_rdata = pin_direction_bits;
         end
         FPP_OFS_ANALOG_SEL: begin
            next_rdata = analog_select_bits;
         end
         FPP_OFS_INTR_CTL_TWO: begin
            next_rdata = interrupt_control_two;
         end
         FPP_OFS_CFG_THREE_HIGH: begin
            next_rdata = config_word_three_high;
         end
         FPP_OFS_CFG_FOUR_LOW: begin
            next_rdata = config_word_four_low;
         end
         default: begin
            next_rdata = FPP_READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bus_rdata <= FPP_READ_ZERO;
      end else if (bus_req.rd) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= FPP_READ_ZERO;
      end
   end

   // general pin drivers: direction and package decide, analog mode has no say
   always_comb begin
      for (int i = 0; i < FPP_GEN_PINS; i++) begin
         pin_drive.level[i] = output_latch[i];
         pin_drive.oe_n[i] = pin_direction_bits[i] | ~gen_mask[i];
      end
   end

   assign analog_select_out = analog_select_bits[FPP_GEN_PINS-1:0];

   // weak pull-ups: input pin forced by master clear or low-voltage programming, companion pins never forced
   assign input_pin_pullup_forced = master_clear_select | low_voltage_program_enable;
   assign weak_pullup.input_pin = input_pin_pullup_forced |
      (input_pin_pullup_enable & ~global_pullup_disable_n);
   assign weak_pullup.companion = companion_port_pullup_bits &
      {FPP_COMPANION_PINS{~global_pullup_disable_n}};

   // master clear request from the active-low pad
   always_ff @(posedge clk) begin
      if (srst) begin
         master_clear_input <= 1'b0;
      end else begin
         master_clear_input <= master_clear_select & ~pin_level[FPP_INPUT_PIN_BIT];
      end
   end

endmodule

`default_nettype wire

/* File: verification/fpp_port_chk.sv */
// port-level checker of the four-pin port
`timescale 1ns/1ns
`default_nettype none

module fpp_port_chk
   import fpp_pkg::*;
#(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register bus
   input wire fpp_bus_req_type bus_req,
   input wire logic [FPP_DATA_W-1:0] bus_rdata,
   // pins
   input wire logic [FPP_ALL_PINS-1:0] pin_in,
   input wire fpp_pin_drive_type pin_drive,
   input wire logic [FPP_COMPANION_PINS-1:0] companion_port_pullup_bits,
   input wire fpp_pullup_type weak_pullup,
   input wire logic [FPP_GEN_PINS-1:0] analog_select_out,
   input wire logic master_clear_input
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_reset_state: assert property ($fell(srst) |-> pin_drive.oe_n == 3'h7
      && analog_select_out == (LARGE_PACKAGE ? 3'h7 : 3'h0)
      && weak_pullup.companion == 8'h00) else $error("reset state");
   a_latch_drive: assert property (bus_req.wr && bus_req.addr == 3'h1
      |=> pin_drive.level == ($past(bus_req.wdata[2:0]) & (LARGE_PACKAGE ? 3'h7 : 3'h0)))
      else $error("latch drive");
   a_dir_drive: assert property (bus_req.wr && bus_req.addr == 3'h2
      |=> pin_drive.oe_n == ($past(bus_req.wdata[2:0]) | (LARGE_PACKAGE ? 3'h0 : 3'h7)))
      else $error("direction");
   a_analog_keeps_dir: assert property (bus_req.wr && bus_req.addr == 3'h3
      |=> $stable(pin_drive.oe_n)) else $error("analog moved driver");
   a_latch_read: assert property (bus_req.rd && bus_req.addr == 3'h1
      |=> bus_rdata[2:0] == pin_drive.level) else $error("latch read");
   a_analog_zero: assert property (bus_req.rd && bus_req.addr == 3'h0
      |=> (bus_rdata[2:0] & $past(analog_select_out)) == 3'h0) else $error("analog read");
   a_global_off: assert property (bus_req.wr && bus_req.addr == 3'h4 && bus_req.wdata[7]
      |=> weak_pullup.companion == 8'h00) else $error("global disable");
   a_pullup_follow: assert property (bus_req.wr && bus_req.addr == 3'h4
      && !bus_req.wdata[7] |=> weak_pullup.companion == companion_port_pullup_bits)
      else $error("pull-up");
   a_force_pullup: assert property (bus_req.wr && bus_req.addr == 3'h5
      && bus_req.wdata[7] |=> weak_pullup.input_pin) else $error("forced pull-up");
   a_clear_hides: assert property (master_clear_input
      && bus_req.rd && bus_req.addr == 3'h0 |=> !bus_rdata[3])
      else $error("master clear pin read");
endmodule

bind fpp_port fpp_port_chk #(.LARGE_PACKAGE(LARGE_PACKAGE)) chk_u (.clk(clk), .srst(srst),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_drive(pin_drive),
   .companion_port_pullup_bits(companion_port_pullup_bits), .weak_pullup(weak_pullup),
   .analog_select_out(analog_select_out), .master_clear_input(master_clear_input));

`default_nettype wire

/* File: verification/fpp_board.sv */
// board model that resolves the pad levels
`timescale 1ns/1ns
`default_nettype none

module fpp_board
   import fpp_pkg::*;
(
   // clock
   input wire logic clk,
   // port side
   input wire fpp_pin_drive_type pin_drive,
   input wire fpp_pullup_type weak_pullup,
   // board drive per pin
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_level,
   // pad levels
   output logic [3:0] pin_in
);
   logic flip = 1'b0;

   // floating pads wander
   always @(posedge clk) begin
      flip <= ~flip;
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!pin_drive.oe_n[i]) begin
            pin_in[i] = pin_drive.level[i];
         end else begin
            pin_in[i] = ext_en[i] ? ext_level[i] : flip;
         end
      end
      pin_in[3] = ext_en[3] ? ext_level[3] : (weak_pullup.input_pin | flip);
   end
endmodule

`default_nettype wire

/* File: verification/tb_fpp_port.sv */
// self-checking bench of the four-pin port
`timescale 1ns/1ns
`default_nettype none

module tb_fpp_port;
   import fpp_pkg::*;
   typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e;} fpp_row_type;
   logic clk = 1'b0;
   logic srst = 1'b1;
   fpp_bus_req_type bus_req = '0;
   logic [7:0] bus_rdata;
   logic [3:0] pin_in;
   fpp_pin_drive_type pin_drive;
   logic [7:0] companion_port_pullup_bits = 8'h00;
   fpp_pullup_type weak_pullup;
   logic [2:0] analog_select_out;
   logic master_clear_input;
   logic [7:0] small_rdata;
   fpp_pin_drive_type small_drive;
   fpp_pullup_type small_pullup;
   logic [2:0] small_analog;
   logic small_clear;
   logic [3:0] ext_en = 4'h8;
   logic [3:0] ext_level = 4'hf;
   logic [7:0] rv;
   logic [7:0] rv_small;
   int fail_count = 0;
   int checks = 0;
   fpp_row_type rows [14] = '{
      '{1'b0, 3'h0, 8'h00, 8'h00},
      '{1'b0, 3'h1, 8'h00, 8'h00},
      '{1'b0, 3'h2, 8'h00, 8'h07},
      '{1'b0, 3'h3, 8'h00, 8'h07},
      '{1'b0, 3'h4, 8'h00, 8'h80},
      '{1'b0, 3'h5, 8'h00, 8'h80},
      '{1'b0, 3'h6, 8'h00, 8'h04},
      '{1'b1, 3'h1, 8'hff, 8'h07},
      '{1'b1, 3'h2, 8'h85, 8'h85},
      '{1'b1, 3'h3, 8'hff, 8'h07},
      '{1'b1, 3'h4, 8'h7f, 8'h00},
      '{1'b1, 3'h5, 8'h7f, 8'h00},
      '{1'b1, 3'h6, 8'hfb, 8'h00},
      '{1'b1, 3'h7, 8'hff, 8'h00}};

   always #10 clk = ~clk;

   fpp_port dut_u (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .pin_in(pin_in), .pin_drive(pin_drive), .weak_pullup(weak_pullup),
      .companion_port_pullup_bits(companion_port_pullup_bits),
      .analog_select_out(analog_select_out), .master_clear_input(master_clear_input));
   // small package variant on the same bus and pads
   fpp_port #(.LARGE_PACKAGE(1'b0)) dut_small_u (.clk(clk), .srst(srst), .bus_req(bus_req),
      .bus_rdata(small_rdata), .pin_in(pin_in), .pin_drive(small_drive),
      .weak_pullup(small_pullup), .companion_port_pullup_bits(companion_port_pullup_bits),
      .analog_select_out(small_analog), .master_clear_input(small_clear));
   fpp_board board_u (.clk(clk), .pin_drive(pin_drive), .weak_pullup(weak_pullup),
      .ext_en(ext_en),
      .ext_level(ext_level), .pin_in(pin_in));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      rv = bus_rdata;
      rv_small = small_rdata;
   endtask

   task automatic wait_clear(input logic v);
      int n;
      for (n = 0; n < 20 && master_clear_input !== v; n++) begin
         @(posedge clk);
         #1;
      end
      chk("master clear", {7'h0, v}, {7'h0, master_clear_input});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk("reset oe_n", 8'h07, {5'h0, pin_drive.oe_n});
      chk("reset pull-up", 8'h01, {7'h0, weak_pullup.input_pin});
      for (int i = 0; i < 14; i++) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d);
         end
         rd(rows[i].a);
         chk("register", rows[i].e, rv);
      end
      $display("register table done");
      wr(3'h2, 8'h00);
      chk("oe_n analog", 8'h00, {5'h0, pin_drive.oe_n});
      wr(3'h1, 8'h05);
      chk("level", 8'h05, {5'h0, pin_drive.level});
      wr(3'h2, 8'h02);
      chk("oe_n", 8'h02, {5'h0, pin_drive.oe_n});
      wr(3'h3, 8'h00);
      @(posedge clk);
      ext_en <= 4'ha;
      ext_level <= 4'ha;
      repeat (8) @(posedge clk);
      rd(3'h0);
      chk("port data", 8'h0f, rv);
      wr(3'h3, 8'h02);
      rd(3'h0);
      chk("port analog", 8'h0d, rv);
      rd(3'h1);
      chk("latch", 8'h05, rv);
      $display("drive test done");
      @(posedge clk);
      companion_port_pullup_bits <= 8'ha5;
      wr(3'h4, 8'h00);
      chk("companion", 8'ha5, weak_pullup.companion);
      chk("input pull-up", 8'h00, {7'h0, weak_pullup.input_pin});
      wr(3'h2, 8'h82);
      chk("input pull-up", 8'h01, {7'h0, weak_pullup.input_pin});
      wr(3'h4, 8'h80);
      chk("companion off", 8'h00, weak_pullup.companion);
      chk("input pull-up", 8'h00, {7'h0, weak_pullup.input_pin});
      wr(3'h6, 8'h04);
      chk("lvp pull-up", 8'h01, {7'h0, weak_pullup.input_pin});
      $display("pull-up test done");
      wr(3'h5, 8'h80);
      @(posedge clk);
      ext_level <= 4'h2;
      wait_clear(1'b1);
      chk("small clear", 8'h01, {7'h0, small_clear});
      rd(3'h0);
      chk("port clear", 8'h05, rv);
      @(posedge clk);
      ext_level <= 4'ha;
      wait_clear(1'b0);
      $display("master clear test done");
      wr(3'h2, 8'h87);
      chk("small oe_n", 8'h07, {5'h0, small_drive.oe_n});
      chk("small level", 8'h00, {5'h0, small_drive.level});
      chk("small analog", 8'h00, {5'h0, small_analog});
      chk("small pull-up", 8'h01, {7'h0, small_pullup.input_pin});
      rd(3'h2);
      chk("small direction", 8'h80, rv_small);
      wr(3'h5, 8'h00);
      rd(3'h0);
      chk("small port data", 8'h08, rv_small);
      $display("small package test done");
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk("reset again oe_n", 8'h07, {5'h0, pin_drive.oe_n});
      rd(3'h4);
      chk("reset again disable", 8'h80, rv);
      $display("mid-run reset test done");
      results();
   end
endmodule

`default_nettype wire
